/* File: rtl/sxc_ctrl.sv */
// Serial transfer control with clock dividers behind a Wishbone slave.
// Notes on behaviour
// - Word count 00 sends one word, 01 sends two words back to back.
// - Bit length field gives 1 to 31 bits; code zero gives 32 bits.
// - Launch bit set: data out changes on falling clock, else rising.
// - Sample bit set: data in taken on falling clock, else rising.
// - Master: writing go starts a transfer with the current settings.
// - Slave: writing go arms the device for an external master.
// - Writing zero to go during a transfer stops it.
// - Go reads one throughout a transfer and clears itself at the end.
// - Master clock is peripheral clock over twice primary divider plus one.
// - Secondary divider gives alternative rate only with variable clock on.
// - Clock polarity bit sets the idle level of the serial clock.
`include "sxc_params.svh"
module sxc_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    input wire logic serial_clock_pin_i,
    output logic sdo_o,
    output logic sdo_oe_n,
    input wire logic sdi_i,
    input wire logic sel_in_n
);
    // -----------------------------------------------------------------
    // Decoding helpers
    // -----------------------------------------------------------------
    function automatic logic [5:0] word_len(input logic [4:0] code);
        word_len = (code == 5'h00) ? `SXC_LEN_FULL : {1'b0, code};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    sxc_pkg::sxc_state_t state_ff, nxt_state;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] div_ff, nxt_div;
    sxc_pkg::sxc_word_t tx_ff [2];
    sxc_pkg::sxc_word_t nxt_tx [2];
    sxc_pkg::sxc_word_t rx_ff [2];
    sxc_pkg::sxc_word_t nxt_rx [2];
    sxc_pkg::sxc_word_t shift_ff, nxt_shift;
    logic [31:0] dat_ff, nxt_dat;
    logic ack_ff, nxt_ack;
    logic [15:0] hc_ff, nxt_hc;
    logic [6:0] edges_ff, nxt_edges;
    logic [5:0] nsamp_ff, nxt_nsamp;
    logic [4:0] bit_ix_ff, nxt_bit_ix;
    logic word_ff, nxt_word;
    logic sclk_ff, nxt_sclk;
    logic sclk_prev_ff, nxt_sclk_prev;
    logic sdo_ff, nxt_sdo;

    logic busy, slave, cpol, acc, ctrl_wr, go_wr, stop_wr, start;
    logic [5:0] len;
    logic [15:0] div_lim;
    logic m_tick, s_edge, edge_any, new_lvl, smp, lch, end_w, last_w;
    sxc_pkg::sxc_word_t shifted;

    assign busy = (state_ff == sxc_pkg::SXC_SHIFT);
    assign slave = ctrl_ff[`SXC_SLAVE];
    assign cpol = ctrl_ff[`SXC_CPOL];
    assign len = word_len(ctrl_ff[`SXC_LEN_HI:`SXC_LEN_LO]);
    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign ctrl_wr = acc & wb_we_i & (wb_adr_i == `SXC_OFS_CTRL) & wb_sel_i[0];
    assign go_wr = ctrl_wr & wb_dat_i[`SXC_GO];
    assign stop_wr = ctrl_wr & ~wb_dat_i[`SXC_GO] & busy;
    assign start = go_wr & ~busy;

    // Second word of a burst runs at the secondary rate when enabled.
    assign div_lim = (ctrl_ff[`SXC_VARCLK] & word_ff) ?
                     div_ff[`SXC_DIV2_HI:`SXC_DIV2_LO] :
                     div_ff[`SXC_DIV1_HI:`SXC_DIV1_LO];
    assign m_tick = busy & ~slave & (hc_ff == div_lim);
    assign s_edge = busy & slave & ~sel_in_n &
                    (serial_clock_pin_i != sclk_prev_ff);
    assign edge_any = slave ? s_edge : m_tick;
    assign new_lvl = slave ? serial_clock_pin_i : ~sclk_ff;
    assign smp = edge_any & (~new_lvl == ctrl_ff[`SXC_RXNEG]);
    assign lch = edge_any & (~new_lvl == ctrl_ff[`SXC_TXNEG]);
    assign shifted = {shift_ff[30:0], sdi_i};
    assign end_w = edge_any & (edges_ff == {len, 1'b0} - 7'h01);
    assign last_w = end_w & (word_ff |
                    (ctrl_ff[`SXC_NUM_HI:`SXC_NUM_LO] != `SXC_NUM_TWO));

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_ctrl = ctrl_ff;
        nxt_div = div_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_shift = shift_ff;
        nxt_dat = dat_ff;
        nxt_ack = acc;
        nxt_hc = hc_ff;
        nxt_edges = edges_ff;
        nxt_nsamp = nsamp_ff;
        nxt_bit_ix = bit_ix_ff;
        nxt_word = word_ff;
        nxt_sclk = sclk_ff;
        nxt_sclk_prev = serial_clock_pin_i;
        nxt_sdo = sdo_ff;
        if (acc & ~wb_we_i) begin
            case (wb_adr_i)
                `SXC_OFS_CTRL: nxt_dat = {ctrl_ff[31:1], busy};
                `SXC_OFS_DIV: nxt_dat = div_ff;
                `SXC_OFS_TX0: nxt_dat = tx_ff[0];
                `SXC_OFS_TX1: nxt_dat = tx_ff[1];
                `SXC_OFS_RX0: nxt_dat = rx_ff[0];
                `SXC_OFS_RX1: nxt_dat = rx_ff[1];
                default: nxt_dat = 32'h0000_0000;
            endcase
        end
        if (acc & wb_we_i) begin
            case (wb_adr_i)
                `SXC_OFS_CTRL: begin
                    nxt_ctrl = merge(ctrl_ff, wb_dat_i, wb_sel_i) &
                               `SXC_CTRL_MASK;
                end
                `SXC_OFS_DIV: nxt_div = merge(div_ff, wb_dat_i, wb_sel_i);
                `SXC_OFS_TX0: nxt_tx[0] = merge(tx_ff[0], wb_dat_i, wb_sel_i);
                `SXC_OFS_TX1: nxt_tx[1] = merge(tx_ff[1], wb_dat_i, wb_sel_i);
                default: nxt_dat = dat_ff;
            endcase
        end
        case (state_ff)
            sxc_pkg::SXC_IDLE: begin
                nxt_sclk = cpol;
                nxt_hc = 16'h0000;
                if (start) begin
                    nxt_state = sxc_pkg::SXC_SHIFT;
                    nxt_edges = 7'h00;
                    nxt_nsamp = 6'h00;
                    nxt_word = 1'b0;
                    nxt_shift = 32'h0000_0000;
                    nxt_bit_ix = 5'(len - 6'h01);
                    nxt_sdo = tx_ff[0][5'(len - 6'h01)];
                end
            end
            sxc_pkg::SXC_SHIFT: begin
                if (~slave) begin
                    nxt_hc = m_tick ? 16'h0000 : hc_ff + 16'h0001;
                    if (m_tick) begin
                        nxt_sclk = ~sclk_ff;
                    end
                end
                if (edge_any) begin
                    nxt_edges = edges_ff + 7'h01;
                end
                if (smp) begin
                    nxt_shift = shifted;
                    nxt_nsamp = nsamp_ff + 6'h01;
                end
                if (lch & (nsamp_ff != 6'h00) & (nsamp_ff < len)) begin
                    nxt_bit_ix = bit_ix_ff - 5'h01;
                    nxt_sdo = tx_ff[word_ff][bit_ix_ff - 5'h01];
                end
                if (end_w) begin
                    nxt_rx[word_ff] = smp ? shifted : shift_ff;
                    nxt_edges = 7'h00;
                    nxt_nsamp = 6'h00;
                    nxt_shift = 32'h0000_0000;
                    nxt_bit_ix = 5'(len - 6'h01);
                    nxt_hc = 16'h0000;
                    if (last_w) begin
                        nxt_state = sxc_pkg::SXC_IDLE;
                    end else begin
                        nxt_word = 1'b1;
                        nxt_sdo = tx_ff[1][5'(len - 6'h01)];
                    end
                end
                if (stop_wr) begin
                    nxt_state = sxc_pkg::SXC_IDLE;
                    nxt_sclk = cpol;
                end
            end
            default: nxt_state = sxc_pkg::SXC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= sxc_pkg::SXC_IDLE;
            ctrl_ff <= `SXC_CTRL_RESET;
            div_ff <= `SXC_DIV_RESET;
            tx_ff <= '{default: 32'h0000_0000};
            rx_ff <= '{default: 32'h0000_0000};
            shift_ff <= 32'h0000_0000;
            dat_ff <= 32'h0000_0000;
            ack_ff <= 1'b0;
            hc_ff <= 16'h0000;
            edges_ff <= 7'h00;
            nsamp_ff <= 6'h00;
            bit_ix_ff <= 5'h00;
            word_ff <= 1'b0;
            sclk_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
            sdo_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ctrl_ff <= nxt_ctrl;
            div_ff <= nxt_div;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            shift_ff <= nxt_shift;
            dat_ff <= nxt_dat;
            ack_ff <= nxt_ack;
            hc_ff <= nxt_hc;
            edges_ff <= nxt_edges;
            nsamp_ff <= nxt_nsamp;
            bit_ix_ff <= nxt_bit_ix;
            word_ff <= nxt_word;
            sclk_ff <= nxt_sclk;
            sclk_prev_ff <= nxt_sclk_prev;
            sdo_ff <= nxt_sdo;
        end
    end

    // -----------------------------------------------------------------
    // Pins and bus outputs
    // -----------------------------------------------------------------
    // The slave drives data out only while its select is active.
    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign serial_clock_pin_o = sclk_ff;
    assign serial_clock_pin_oe_n = slave;
    assign sdo_o = sdo_ff;
    assign sdo_oe_n = slave ? (sel_in_n | ~busy) : 1'b0;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_go_master;
        start & ~slave;
    endsequence

    sequence s_go_slave;
        start & slave;
    endsequence

    a_master_start: assert property (
        s_go_master |=> busy ##0 sclk_ff == cpol ##0 edges_ff == 7'h00)
        else $error("master go did not start a transfer");
    a_slave_armed: assert property (
        s_go_slave |=> busy ##0 serial_clock_pin_oe_n ##0 hc_ff == 16'h0000)
        else $error("slave go did not arm the device");
    a_stop_write: assert property (
        stop_wr |=> !busy ##0 sclk_ff == cpol)
        else $error("writing zero to go did not stop");
    a_busy_holds: assert property (
        busy & ~last_w & ~stop_wr |=> busy)
        else $error("go dropped during a transfer");
    a_word_count: assert property (
        end_w & ~word_ff &
        (ctrl_ff[`SXC_NUM_HI:`SXC_NUM_LO] == `SXC_NUM_TWO) & ~stop_wr
        |=> busy & word_ff)
        else $error("burst did not continue with second word");
    a_bit_count: assert property (
        end_w |-> (nsamp_ff + {5'h00, smp}) == len)
        else $error("word did not carry the programmed bit count");
    a_launch_edge: assert property (
        busy & $past(busy) & $changed(sdo_ff) |-> $past(lch | end_w))
        else $error("data out changed off the launch edge");
    a_sample_edge: assert property (
        busy & (nsamp_ff > $past(nsamp_ff)) |-> $past(smp))
        else $error("data in sampled off the sample edge");
    a_divider_rate: assert property (
        m_tick & ~ctrl_ff[`SXC_VARCLK] |->
        hc_ff == div_ff[`SXC_DIV1_HI:`SXC_DIV1_LO])
        else $error("half period differs from primary divider");
    a_second_divider: assert property (
        m_tick & ctrl_ff[`SXC_VARCLK] & word_ff |->
        hc_ff == div_ff[`SXC_DIV2_HI:`SXC_DIV2_LO])
        else $error("second word not at secondary rate");
    a_idle_level: assert property (
        !busy & $past(!busy) |-> serial_clock_pin_o == $past(cpol))
        else $error("serial clock not at idle level");
    a_slave_no_div: assert property (
        busy & slave |-> hc_ff == 16'h0000 && serial_clock_pin_oe_n)
        else $error("slave used the divider");
endmodule

/* File: rtl/sxc_params.svh */
// Register offsets, field positions and reset values of the transfer control.
`ifndef SXC_PARAMS_SVH
`define SXC_PARAMS_SVH
`define SXC_OFS_CTRL 8'h00
`define SXC_OFS_DIV 8'h04
`define SXC_OFS_TX0 8'h10
`define SXC_OFS_TX1 8'h14
`define SXC_OFS_RX0 8'h20
`define SXC_OFS_RX1 8'h24
`define SXC_CTRL_RESET 32'h0000_0000
`define SXC_DIV_RESET 32'h0000_0000
`define SXC_CTRL_MASK 32'h0084_0BFE
`define SXC_GO 0
`define SXC_RXNEG 1
`define SXC_TXNEG 2
`define SXC_LEN_HI 7
`define SXC_LEN_LO 3
`define SXC_NUM_HI 9
`define SXC_NUM_LO 8
`define SXC_CPOL 11
`define SXC_SLAVE 18
`define SXC_VARCLK 23
`define SXC_DIV1_HI 15
`define SXC_DIV1_LO 0
`define SXC_DIV2_HI 31
`define SXC_DIV2_LO 16
`define SXC_NUM_TWO 2'h1
`define SXC_LEN_FULL 6'h20
`define SXC_SLAVE_MIN_RATIO 5
`endif

/* File: rtl/sxc_pkg.sv */
// Types shared by the transfer control.
package sxc_pkg;
    typedef enum logic [1:0] {
        SXC_IDLE = 2'h1,
        SXC_SHIFT = 2'h2
    } sxc_state_t;
    typedef logic [31:0] sxc_word_t;
endpackage

/* File: tb/sxc_partner.sv */
// External serial device that shifts a pattern out and captures the data line.
module sxc_partner (
    input wire logic sclk,
    input wire logic sdo,
    input wire logic load,
    input wire logic [31:0] tx_word,
    input wire logic samp_fall,
    input wire logic launch_fall,
    output logic sdi,
    output logic [31:0] rx_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] shift;
    logic seen;
    assign sdi = shift[31];
    always @(posedge load) begin
        shift = tx_word;
        rx_word = 32'h0000_0000;
        seen = 1'b0;
    end
    // No bit goes out before the first one has been taken by the device.
    always @(sclk) begin
        if (sclk === !samp_fall) begin
            rx_word = {rx_word[30:0], sdo};
            seen = 1'b1;
        end else if (sclk === !launch_fall && seen) begin
            shift = {shift[30:0], ~shift[30]};
        end
    end
endmodule

/* File: tb/test_spi_transfer_control_divider.sv */
// Self-checking bench for the serial transfer control.
module test_spi_transfer_control_divider;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sdo_o;
    logic serial_clock_pin_o, serial_clock_pin_oe_n, sdo_oe_n, sel_in_n;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, p_rx, rd;
    logic tb_sclk, tb_sdi, p_sdi, slave, load, s_fall, l_fall, sclk_prev;
    logic sclk_w, sdi_w;
    int error_cnt, comparisons, n_tog, cnt, hp_first, hp_last, k;
    localparam logic [31:0] PAT = 32'hc3a5_96e1;
    localparam logic [31:0] TX0 = 32'h5a3c_e187;
    localparam logic [31:0] TX1 = 32'h0f96_4bd2;
    // The clock wire follows whichever party has its driver enabled.
    assign sclk_w = serial_clock_pin_oe_n ? tb_sclk : serial_clock_pin_o;
    assign sdi_w = slave ? tb_sdi : p_sdi;
    sxc_ctrl u_sxc_ctrl (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .serial_clock_pin_o, .serial_clock_pin_oe_n,
        .serial_clock_pin_i(sclk_w), .sdo_o, .sdo_oe_n, .sdi_i(sdi_w),
        .sel_in_n);
    sxc_partner u_sxc_partner (.sclk(sclk_w), .sdo(sdo_o), .load,
        .tx_word(PAT), .samp_fall(s_fall), .launch_fall(l_fall),
        .sdi(p_sdi), .rx_word(p_rx));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Counts clock toggles and their spacing where the pin has settled.
    always @(negedge sys_clk) begin
        if (serial_clock_pin_o !== sclk_prev) begin
            if (n_tog == 1) hp_first = cnt;
            hp_last = cnt;
            n_tog++;
            cnt = 0;
        end
        cnt++;
        sclk_prev = serial_clock_pin_o;
    end
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) error_cnt++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic xfer(input logic [31:0] c, d, input int len, nw, hl);
        int n;
        logic [31:0] m;
        m = (len == 32) ? 32'hffff_ffff : (32'h0000_0001 << len) - 1;
        s_fall <= ~c[2];
        l_fall <= ~c[1];
        wb(1'b1, 8'h00, c);
        load <= 1'b1;
        wb(1'b1, 8'h04, d);
        load <= 1'b0;
        wb(1'b1, 8'h10, TX0);
        wb(1'b1, 8'h14, TX1);
        check("idle", 32'(serial_clock_pin_o), 32'(c[11]));
        n_tog = 0;
        wb(1'b1, 8'h00, c | 32'h0000_0001);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check("busy", rd & 32'h0000_0001, 32'h0000_0001);
        check("oe", 32'({sdo_oe_n, serial_clock_pin_oe_n}),
            32'h0000_0000);
        n = 0;
        while (rd[0] !== 1'b0 && n < 600) begin
            wb(1'b0, 8'h00, 32'h0000_0000);
            n++;
        end
        check("done", rd & 32'h0000_0001, 32'h0000_0000);
        check("toggles", n_tog, 2 * len * nw);
        check("half", hp_first, d[15:0] + 1);
        check("last", hp_last, hl);
        check("idle2", 32'(serial_clock_pin_o), 32'(c[11]));
        check("peer", p_rx & (nw == 2 ? 32'h0000_ffff : m),
            nw == 2 ? {16'h0000, TX0[7:0], TX1[7:0]} : TX0 & m);
        wb(1'b0, 8'h20, 32'h0000_0000);
        check("rx0", rd & m, (PAT >> (32 - len)) & m);
        if (nw == 2) begin
            wb(1'b0, 8'h24, 32'h0000_0000);
            check("rx1", rd & m, (PAT >> 16) & m);
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        reset_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, tb_sclk, tb_sdi, slave, load} = 7'h00;
        {s_fall, l_fall, sel_in_n} = 3'h1;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0000_0000;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, 8'h04, 32'h0000_0000);
        check("div_rst", rd, 32'h0000_0000);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check("ctrl_rst", rd, 32'h0000_0000);
        wb(1'b1, 8'h04, 32'ha5a5_5a5a);
        wb(1'b0, 8'h04, 32'h0000_0000);
        check("div_rw", rd, 32'ha5a5_5a5a);
        wb(1'b0, 8'h30, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        xfer(32'h0000_0044, 32'h0000_0000, 8, 1, 1);
        xfer(32'h0000_0802, 32'h0000_0002, 32, 1, 3);
        xfer(32'h0000_02fc, 32'h0000_0001, 31, 1, 2);
        xfer(32'h0000_0b44, 32'h0000_0000, 8, 1, 1);
        xfer(32'h0080_0144, 32'h0003_0000, 8, 2, 4);
        n_tog = 0;
        wb(1'b1, 8'h04, 32'h0000_000f);
        wb(1'b1, 8'h00, 32'h0000_0004);
        wb(1'b1, 8'h00, 32'h0000_0005);
        repeat (20) @(posedge sys_clk);
        wb(1'b1, 8'h00, 32'h0000_0004);
        wb(1'b0, 8'h00, 32'h0000_0000);
        check("stop", rd & 32'h0000_0001, 32'h0000_0000);
        k = n_tog;
        repeat (80) @(posedge sys_clk);
        check("stopped", n_tog, k);
        slave <= 1'b1;
        s_fall <= 1'b0;
        load <= 1'b1;
        wb(1'b1, 8'h04, 32'h0000_0007);
        load <= 1'b0;
        wb(1'b1, 8'h00, 32'h0004_0144);
        wb(1'b1, 8'h00, 32'h0004_0145);
        check("s_oe", 32'({sdo_oe_n, serial_clock_pin_oe_n}),
            32'h0000_0003);
        sel_in_n <= 1'b0;
        @(posedge sys_clk);
        check("s_oe1", 32'({sdo_oe_n, serial_clock_pin_oe_n}),
            32'h0000_0001);
        for (int i = 0; i < 16; i++) begin
            tb_sdi <= PAT[31 - i];
            repeat (5) @(posedge sys_clk);
            tb_sclk <= 1'b1;
            repeat (5) @(posedge sys_clk);
            tb_sclk <= 1'b0;
        end
        repeat (5) @(posedge sys_clk);
        sel_in_n <= 1'b1;
        tb_sdi <= ~tb_sdi;
        wb(1'b0, 8'h00, 32'h0000_0000);
        check("s_done", rd & 32'h0000_0001, 32'h0000_0000);
        check("s_oe2", 32'(sdo_oe_n), 32'h0000_0001);
        wb(1'b0, 8'h20, 32'h0000_0000);
        check("s_rx0", rd & 32'h0000_00ff, PAT >> 24);
        wb(1'b0, 8'h24, 32'h0000_0000);
        check("s_rx1", rd & 32'h0000_00ff, (PAT >> 16) & 32'h0000_00ff);
        check("s_peer", p_rx & 32'h0000_ffff, {TX0[7:0], TX1[7:0]});
        stop_test();
    end
endmodule
